//--- sebs_defines.vh
// Shared constants of the serial EEPROM bus slave
`ifndef SEBS_DEFINES_VH
`define SEBS_DEFINES_VH
`define SEBS_CLK_HZ         40000000
`define SEBS_TYPE_CODE      4'ha
`define SEBS_TYPE_MSB       7
`define SEBS_TYPE_LSB       4
`define SEBS_SEL_MSB        3
`define SEBS_SEL_LSB        1
`define SEBS_RW_BIT         0
`define SEBS_PAGE_BITS      6
`define SEBS_GLITCH_NS      50
`define SEBS_GLITCH_CYC     ((`SEBS_GLITCH_NS * 40 + 999) / 1000 + 1)
`define SEBS_WRITE_MS_HI    10
`define SEBS_WRITE_MS_LO    15
`define SEBS_WRITE_CYC_HI   (`SEBS_WRITE_MS_HI * (`SEBS_CLK_HZ / 1000))
`define SEBS_WRITE_CYC_LO   (`SEBS_WRITE_MS_LO * (`SEBS_CLK_HZ / 1000))
`endif

//--- sebs_filter.v
// Two-stage synchroniser followed by a stable-level glitch filter
`timescale 1ns/1ps
`default_nettype none
module sebs_filter #(
    parameter CYC = 3
) (
    input  wire ref_clk_i,
    input  wire rst_i,
    input  wire pin_i,
    output reg  level_o
);
    reg       sync_a;   // First stage, read only by sync_b
    reg       sync_b;   // Second stage
    reg [3:0] cnt;      // Cycles the new level has held

    // Synchronise, then accept a level only after it held CYC cycles
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            sync_a  <= 1'b1;
            sync_b  <= 1'b1;
            cnt     <= 4'h0;
            level_o <= 1'b1;
        end
        else
        begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            if (sync_b == level_o)
                cnt <= 4'h0;                      // Level unchanged
            else if (cnt == CYC[3:0] - 4'h1)
            begin
                level_o <= sync_b;                // Held long enough
                cnt     <= 4'h0;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule // sebs_filter
`default_nettype wire

//--- sebs_top.v
// Two-wire serial EEPROM slave: bus protocol, page buffer, array model
// How it works
// - sample on clock rise, drive on fall
// - data pin only pulled low or released
// - data falling with clock high starts
// - stop ends read, or starts timed write
// - eight bits then ninth clock acknowledge
// - acknowledge every write byte with zero
// - read ack zero gives next byte
// - no ack: stay released, send nothing
// - address word is type, select, direction
// - mismatch returns to standby, no acknowledge
// - byte write: two address bytes, data
// - after stop, ignore bus until written; a start still passes and a read address word is acknowledged
// - more bytes form page write up to 64
// - page offset wraps inside the page
// - busy device refuses write address word acknowledge
// - protect pin blocks upper eighth writes
// - counter holds last address plus one
// - current address wraps by array, page
// - random read uses dummy write first
// - sequential read increments, wraps at end
// - timed write ends within ten milliseconds
// - glitches under 50 ns are ignored
`timescale 1ns/1ps
`default_nettype none
`include "sebs_defines.vh"
module sebs_top #(
    parameter AW        = 15,                    // Address bits: 14 or 15
    parameter WRITE_CYC = `SEBS_WRITE_CYC_HI     // Internal write cycles
) (
    input  wire       ref_clk_i,
    input  wire       rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_o,
    output reg        sda_oe_o,
    input  wire [2:0] device_select_pins_i,
    input  wire       wp_i,
    output reg        busy_o
);
    localparam DEPTH = 1 << AW;                  // Array size in bytes
    localparam PB    = `SEBS_PAGE_BITS;          // Page offset width
    localparam PSIZE = 1 << PB;                  // Page size in bytes
    // Upper eighth starts where the three top address bits are all ones
    localparam [AW-1:0] PROT_BASE = {3'b111, {(AW-3){1'b0}}}; // Protected upper eighth

    // Protocol states
    // Every state but standby and the released wait follows the bus clock;
    // a start always leads back to the address word, so a lost master can
    // recover without a reset
    localparam ST_IDLE  = 3'd0;                  // Standby, waiting for start
    localparam ST_DEV   = 3'd1;                  // Receiving address word
    localparam ST_AHI   = 3'd2;                  // Receiving high address byte
    localparam ST_ALO   = 3'd3;                  // Receiving low address byte
    localparam ST_WDAT  = 3'd4;                  // Receiving write data
    localparam ST_RDAT  = 3'd5;                  // Sending read data
    localparam ST_MACK  = 3'd6;                  // Waiting for master acknowledge
    localparam ST_WAIT  = 3'd7;                  // Released until stop or start

    reg  [7:0]    mem [0:DEPTH-1];               // Nonvolatile array model
    reg  [7:0]    pbuf [0:PSIZE-1];              // Page write buffer
    reg  [PSIZE-1:0] pval;                       // Buffer entries filled
    wire          scl_f;                         // Filtered clock level
    wire          sda_f;                         // Filtered data level
    reg           scl_d;                         // Previous clock level
    reg           sda_d;                         // Previous data level
    reg  [2:0]    state;                         // Protocol state
    reg  [3:0]    bitc;                          // Bit count within a word
    reg  [7:0]    shreg;                         // Shift register
    reg           ack_ph;                        // In acknowledge clock
    reg  [AW-1:0] addr;                          // Current address counter
    reg  [AW-1:0] page_base;                     // Page of the pending write
    reg           wr_pend;                       // Write data received
    reg  [31:0]   wcnt;                          // Internal write timer
    reg  [PB:0]   cidx;                          // Commit index
    reg           commit;                        // Copying buffer to array
    reg           wp_s1;                         // Protect pin, first stage
    reg           wp_s2;                         // Protect pin, second stage
    reg  [2:0]    sel_s1;                        // Select straps, first stage
    reg  [2:0]    sel_s2;                        // Select straps, second stage

    // Glitch filters on both bus inputs
    // They add a few cycles of delay, far less than a bus clock phase,
    // and keep short spikes from looking like edges or start conditions
    sebs_filter #(.CYC(`SEBS_GLITCH_CYC)) u_scl (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pin_i     (scl_i),
        .level_o   (scl_f)
    );
    sebs_filter #(.CYC(`SEBS_GLITCH_CYC)) u_sda (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pin_i     (sda_i),
        .level_o   (sda_f)
    );

    wire scl_rise = scl_f & ~scl_d;
    wire scl_fall = ~scl_f & scl_d;
    wire start_c  = scl_f & scl_d & sda_d & ~sda_f;
    wire stop_c   = scl_f & scl_d & ~sda_d & sda_f;
    // Matching address word; select bits in order A2, A1, A0
    wire type_ok  = shreg[`SEBS_TYPE_MSB:`SEBS_TYPE_LSB] == `SEBS_TYPE_CODE;
    wire sel_ok   = shreg[`SEBS_SEL_MSB:`SEBS_SEL_LSB] == sel_s2;
    // The protect pin is only synchronised, it is never held for an operation
    wire prot     = wp_s2 & (addr >= PROT_BASE);
    // First byte of the current page, and the address left after a page write
    wire [AW-1:0] page_of   = {addr[AW-1:PB], {PB{1'b0}}};
    wire [AW-1:0] wrap_addr = {page_base[AW-1:PB], addr[PB-1:0]};

    // Edge history of the filtered bus levels
    // Reset leaves both at the idle high level, so no false edge follows
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    // Two flip-flops before any logic reads the strap and protect pins
    // Their level keeps following the pins, only delayed by two cycles
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            wp_s1  <= 1'b0;
            wp_s2  <= 1'b0;
            sel_s1 <= 3'h0;
            sel_s2 <= 3'h0;
        end
        else
        begin
            wp_s1  <= wp_i;
            wp_s2  <= wp_s1;
            sel_s1 <= device_select_pins_i;
            sel_s2 <= sel_s1;
        end
    end

    // Internal write timer and buffer commit
    // The buffer is copied in the first cycles of the timed write; the
    // timer alone decides when the device answers polling again, so the
    // copy never shortens the busy time
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            busy_o <= 1'b0;
            wcnt   <= 32'h0;
            commit <= 1'b0;
            cidx   <= {(PB+1){1'b0}};
        end
        else if (state == ST_WDAT && stop_c && wr_pend)
        begin
            busy_o <= 1'b1;
            wcnt   <= 32'h0;
            commit <= 1'b1;
            cidx   <= {(PB+1){1'b0}};
        end
        else if (busy_o)
        begin
            if (commit)
            begin
                // Copy buffered bytes into the array, one per cycle
                if (pval[cidx[PB-1:0]])
                    mem[page_base | {{(AW-PB){1'b0}}, cidx[PB-1:0]}] <= pbuf[cidx[PB-1:0]];
                if (cidx == PSIZE - 1)
                    commit <= 1'b0;
                cidx <= cidx + 1'b1;
            end
            if (wcnt >= WRITE_CYC - 1)
                busy_o <= 1'b0;
            wcnt <= wcnt + 32'h1;
        end
    end

    // Bus protocol engine
    // Bits are taken on the filtered clock rise and the data pin is only
    // changed on the filtered clock fall, so the master sees it settled
    // for the whole high phase. Start and stop are checked before any
    // bit handling, since both happen while the clock stays high.
    // While the timed write runs only a start is let through, which is
    // what makes acknowledge polling possible
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state    <= ST_IDLE;
            bitc     <= 4'h0;
            shreg    <= 8'h00;
            ack_ph   <= 1'b0;
            addr     <= {AW{1'b0}};
            page_base<= {AW{1'b0}};
            wr_pend  <= 1'b0;
            pval     <= {PSIZE{1'b0}};
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else if (busy_o && state == ST_IDLE && !start_c)
        begin
            // Bus activity other than a start is ignored while busy
            // and the data pin stays released
            sda_oe_o <= 1'b0;
        end
        else if (start_c)
        begin
            // Start, repeated start included, resets the word framing
            state    <= ST_DEV;
            bitc     <= 4'h0;
            ack_ph   <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_pend  <= 1'b0;
        end
        else if (stop_c)
        begin
            // A stop ends any transfer; after write data the address
            // stays inside the page that was written
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
            if (state == ST_WDAT && wr_pend)
                addr <= wrap_addr;
        end
        else if (state != ST_IDLE && state != ST_WAIT)
        begin
            if (scl_rise && !ack_ph && state != ST_RDAT)
            begin
                shreg <= {shreg[6:0], sda_f};
                bitc  <= bitc + 4'h1;
            end
            else if (scl_rise && ack_ph && state == ST_MACK)
            begin
                // Master acknowledge bit
                if (!sda_f)
                    state <= ST_RDAT;
                else
                    state <= ST_WAIT;
            end
            else if (scl_rise && state == ST_RDAT)
                bitc <= bitc + 4'h1;
            else if (scl_fall)
            begin
                if (ack_ph)
                begin
                    // End of ninth clock: release and move on
                    ack_ph   <= 1'b0;
                    bitc     <= 4'h0;
                    sda_oe_o <= 1'b0;
                    if (state == ST_RDAT)
                    begin
                        sda_oe_o <= ~mem[addr][7];
                        sda_o    <= 1'b0;
                    end
                    else if (state == ST_MACK)
                        state <= ST_MACK;
                end
                else if (state == ST_RDAT)
                begin
                    // Read byte: next bit out, or release for the
                    // master's acknowledge after the eighth bit
                    if (bitc == 4'h8)
                    begin
                        sda_oe_o <= 1'b0;
                        ack_ph   <= 1'b1;
                        state    <= ST_MACK;
                        addr     <= addr + 1'b1;
                    end
                    else
                    begin
                        sda_oe_o <= ~mem[addr][3'd7 - bitc[2:0]];
                        sda_o    <= 1'b0;
                    end
                end
                else if (bitc == 4'h8)
                begin
                    ack_ph <= 1'b1;
                    case (state)
                        // Address word: acknowledge only a full match, and
                        // no write-direction word while the write runs
                        ST_DEV:
                        begin
                            if (type_ok && sel_ok && !(busy_o && !shreg[`SEBS_RW_BIT]))
                            begin
                                sda_oe_o <= 1'b1;
                                if (shreg[`SEBS_RW_BIT])
                                    state <= ST_RDAT;
                                else
                                    state <= ST_AHI;
                            end
                            else if (busy_o)
                                state <= ST_IDLE;
                            else
                                state <= ST_IDLE;
                        end
                        ST_AHI:
                        begin
                            sda_oe_o <= 1'b1;
                            addr[AW-1:8] <= shreg[AW-9:0];
                            state    <= ST_ALO;
                        end
                        ST_ALO:
                        begin
                            sda_oe_o  <= 1'b1;
                            addr[7:0] <= shreg;
                            state     <= ST_WDAT;
                            pval      <= {PSIZE{1'b0}};
                        end
                        ST_WDAT:
                        begin
                            // Protected bytes are acknowledged but dropped,
                            // so they never start a timed write on their own
                            sda_oe_o <= 1'b1;
                            if (!prot)
                            begin
                                pbuf[addr[PB-1:0]] <= shreg;
                                pval[addr[PB-1:0]] <= 1'b1;
                                wr_pend   <= 1'b1;
                                page_base <= page_of;
                            end
                            // Only the page offset bits advance
                            addr[PB-1:0] <= addr[PB-1:0] + 1'b1;
                        end
                        default:
                            state <= ST_IDLE;
                    endcase
                    sda_o <= 1'b0;
                end
            end
        end
    end
endmodule // sebs_top
`default_nettype wire

//--- sebs_assertions.sv
// Concurrent checks on the pins of the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module sebs_assertions #(
    parameter AW        = 15,
    parameter WRITE_CYC = 400000
) (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [2:0] device_select_pins_i,
    input wire logic       wp_i,
    input wire logic       busy_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    int unsigned busy_cnt;   // Cycles the timed write has run so far
    // Count busy cycles, cleared whenever idle
    always @(posedge ref_clk_i)
        busy_cnt <= (rst_i || !busy_o) ? 0 : busy_cnt + 1;
    a_drive_low_only: assert property (sda_oe_o |-> !sda_o)
        else $error("data driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    a_ack_held: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
        else $error("acknowledge pulse too short");
    a_stop_to_busy: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("timed write began without a stop");
    a_busy_quiet_rise: assert property ($rose(busy_o) |-> !$past(sda_oe_o, 2))
        else $error("timed write began while driving data");
    a_busy_min_len: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("timed write ended at once");
    a_busy_max_len: assert property (busy_o |-> busy_cnt < WRITE_CYC)
        else $error("timed write ran too long");
    a_busy_full_len: assert property ($fell(busy_o) |-> busy_cnt >= WRITE_CYC - 1)
        else $error("timed write ended early");
    c_write: cover property ($rose(busy_o));
    c_done: cover property ($fell(busy_o));
    c_drive: cover property ($rose(sda_oe_o));
endmodule // sebs_assertions
bind sebs_top sebs_assertions #(.AW(AW), .WRITE_CYC(WRITE_CYC)) sebs_assertions_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .device_select_pins_i(device_select_pins_i), .wp_i(wp_i),
    .busy_o(busy_o));
`default_nettype wire

//--- sebs_master.sv
// Two-wire bus master model on the far side of the slave
`timescale 1ns/1ps
`default_nettype none
module sebs_master (
    input  wire logic       ref_clk_i,  // Bench clock that paces the bus
    input  wire logic       sda_i,      // Resolved data wire
    output var  logic       scl_o,      // Bus clock, idle high
    output var  logic       sda_o,      // Data drive, high releases
    output var  logic [8:0] res_o,      // Last byte seen with its acknowledge
    output var  logic       done_o      // Toggles after every byte
);
    initial {scl_o, sda_o, done_o} = 3'h7;
    // Wait n cycles, then step just past the edge
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // One bit: data set in clock low, sampled mid high
    task automatic bt(input logic b, output logic r);
        wt(6);
        sda_o = b;
        wt(18);
        scl_o = 1'b1;
        wt(8);
        r = sda_i;
        wt(8);
        scl_o = 1'b0;
    endtask
    // Start, also usable as a repeated start
    task automatic start();
        wt(8);
        sda_o = 1'b1;
        wt(8);
        scl_o = 1'b1;
        wt(16);
        sda_o = 1'b0;
        wt(16);
        scl_o = 1'b0;
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        wt(8);
        sda_o = 1'b0;
        wt(16);
        scl_o = 1'b1;
        wt(16);
        sda_o = 1'b1;
        wt(24);
    endtask
    // Eight bits most significant first, then the acknowledge clock
    task automatic xfer(input logic [7:0] d, input logic a);
        logic [8:0] r;
        for (int i = 7; i >= 0; i--)
            bt(d[i], r[i]);
        bt(a, r[8]);
        wt(2);
        sda_o = 1'b1;
        res_o = r;
        done_o = ~done_o;
    endtask
endmodule // sebs_master
`default_nettype wire

//--- sebs_top_bench.sv
// Self-checking bench of the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
`include "sebs_defines.vh"
module sebs_top_bench;
    localparam int WC = 800;        // Shortened timed write
    logic       ref_clk_i = 1'b0;   // Bench clock
    logic       rst_i = 1'b1;       // Reset, high
    logic       wp = 1'b0;          // Write protect
    logic [2:0] sel = 3'h0;         // Select straps
    logic [7:0] mem [int];          // Expected array contents
    logic [8:0] exp_q [$];          // Expected bytes in order
    int         cur;                // Expected address counter
    int         err_count = 0;      // Mismatches
    int         comparisons = 0;    // Checks made
    wire        scl, sda_m, sda_o, sda_oe, busy, done;
    wire  [8:0] res;
    wire        sda_w = sda_m & ~sda_oe;   // Open-drain wire with pull-up
    always #12.5 ref_clk_i = ~ref_clk_i;
    sebs_top #(.AW(15), .WRITE_CYC(WC)) sebs_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .device_select_pins_i(sel), .wp_i(wp), .busy_o(busy));
    sebs_master sebs_master_i (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_o(sda_m), .res_o(res), .done_o(done));
    // Compare seen and expected
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Each finished byte is matched to the oldest note
    always @(done)
        if ($time > 0)
            check(res, exp_q.pop_front());
    // Note the expectation, then move the byte
    task automatic xb(input logic [7:0] d, input logic a, input logic [8:0] e);
        exp_q.push_back(e);
        sebs_master_i.xfer(d, a);
    endtask
    // Byte sent by the master; ne is the expected no-acknowledge
    task automatic wb(input logic [7:0] d, input logic ne);
        xb(d, 1'b1, {ne, d});
    endtask
    // Address word in write direction alone
    task automatic poll(input logic ne);
        sebs_master_i.start();
        wb({`SEBS_TYPE_CODE, sel, 1'b0}, ne);
        sebs_master_i.stop();
    endtask
    // Page write of n random bytes, one poll just after the stop, a wait for busy to fall, one more poll
    task automatic wr(input int a, input int n);
        logic [7:0] d;
        logic       st;
        st = 1'b0;
        sebs_master_i.start();
        wb({`SEBS_TYPE_CODE, sel, 1'b0}, 1'b0);
        wb(a[15:8], 1'b0);
        wb(a[7:0], 1'b0);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            wb(d, 1'b0);
            if (!(wp && a[14:12] == 3'h7))
            begin
                mem[(a & 32'h7fc0) | ((a + i) & 32'h3f)] = d;
                st = 1'b1;
            end
        end
        sebs_master_i.stop();
        cur = (a & 32'h7fc0) | ((a + n) & 32'h3f);
        poll(st);
        for (int t = 0; busy && t < 2 * WC; t++)
            @(posedge ref_clk_i);
        poll(1'b0);
    endtask
    // Read n bytes, optionally after a dummy write; one spare byte after the last
    task automatic rd(input int a, input int n, input logic dummy);
        if (dummy)
        begin
            sebs_master_i.start();
            wb({`SEBS_TYPE_CODE, sel, 1'b0}, 1'b0);
            wb(a[15:8] | 8'h80, 1'b0);
            wb(a[7:0], 1'b0);
        end
        sebs_master_i.start();
        wb({`SEBS_TYPE_CODE, sel, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++)
            xb(8'hff, i == n - 1, {i == n - 1, mem[(a + i) & 32'h7fff]});
        wb(8'hff, 1'b1);
        sebs_master_i.stop();
        cur = (a + n) & 32'h7fff;
    endtask
    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(92088));
        sel = 3'($urandom);
        repeat (4) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        for (int k = 0; k < 8; k++)
        begin
            sebs_master_i.start();
            wb({`SEBS_TYPE_CODE, 3'(k), 1'b0}, 3'(k) != sel);
            sebs_master_i.stop();
        end
        sebs_master_i.start();
        wb({~`SEBS_TYPE_CODE, sel, 1'b1}, 1'b1);
        sebs_master_i.stop();
        wr(32'h017e, 66);
        rd(cur, 2, 1'b0);
        rd(32'h017c, 4, 1'b1);
        wr(32'h7ffe, 2);
        wp = 1'b1;
        wr(32'h0000, 1);
        wr(32'h7ffe, 2);
        rd(32'h7ffe, 3, 1'b1);
        wp = 1'b0;
        print_verdict();
    end
    // Watchdog against a hung bus
    initial
    begin
        #2000000;
        err_count++;
        print_verdict();
    end
endmodule // sebs_top_bench
`default_nettype wire
